// file: hw/ppm_pkg.sv
// Shared constants and carrier types for the port pin mode control block.
// Assumes one 32-bit AHB-Lite slave port and pads driven through a cell.
package ppm_pkg;

    // Default geometry of the pin array
    localparam int PIN_W = 8;
    localparam int NUM_PORTS = 7;

    // Register map, byte addresses within the block
    localparam logic [11:0] PORT_STRIDE = 12'h010;
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_IN_MODE = 4'h4;
    localparam logic [3:0] OFS_OUT_MODE = 4'h8;
    localparam logic [3:0] OFS_SKIP = 4'hC;
    localparam logic [11:0] OFS_ASSIGN0 = 12'h100;
    localparam logic [11:0] OFS_ASSIGN1 = 12'h104;

    // Field positions in the second crossbar assignment register
    localparam int XBAR_EN_BIT = 6;
    localparam int WPD_BIT = 7;

    // Reset values
    localparam logic [7:0] RST_IN_MODE = 8'hFF;
    localparam logic [7:0] RST_OUT_MODE = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'hFF;
    localparam logic [7:0] RST_SKIP = 8'h00;
    localparam logic [7:0] RST_ASSIGN = 8'h00;

    // AHB constants
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // Configuration seen by one pin cell
    typedef struct packed {
        logic digital;
        logic push_pull;
        logic force_od;
        logic out_val;
        logic xbar_en;
        logic pu_dis;
    } ppm_cell_cfg_t;

    // Pad-facing controls of one pin cell
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pullup_en;
        logic rx_en;
    } ppm_cell_pad_t;

    // Register write strobe with its address and data
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [31:0] data;
    } ppm_wr_t;

endpackage

// file: hw/ppm_pin_cell.sv
// One port I/O cell: driver, pull-up and receiver control for a pin.
// Assumes the pad input is already synchronous to the system clock.
module ppm_pin_cell (
    input wire ppm_pkg::ppm_cell_cfg_t cfg,
    input wire logic pad_in,
    output ppm_pkg::ppm_cell_pad_t pad,
    output logic rd_bit
);

    logic drive_ok; // Cell may drive at all
    logic open_drain; // High side forbidden
    logic drive_lo; // Pulling the pad to ground
    logic drive_hi; // Pulling the pad to supply

    // Drivers need a digital pin and an enabled crossbar
    always_comb begin
        drive_ok = cfg.digital & cfg.xbar_en;
        open_drain = ~cfg.push_pull | cfg.force_od;
        drive_lo = drive_ok & ~cfg.out_val;
        drive_hi = drive_ok & ~open_drain & cfg.out_val;
    end

    // Pad controls; pull-up only on an undriven digital pin
    always_comb begin
        pad.out = drive_hi;
        pad.oe_n = ~(drive_hi | drive_lo);
        pad.pullup_en = cfg.digital & ~cfg.pu_dis & ~drive_lo & ~drive_hi;
        pad.rx_en = cfg.digital;
        rd_bit = cfg.digital & pad_in;
    end

endmodule

// file: hw/ppm_ahb_slave.sv
// AHB-Lite slave front end: posted writes, reads with one wait state.
// Assumes a single master, single word transfers, OKAY responses only.
module ppm_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output ppm_pkg::ppm_wr_t wr,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data
);

    typedef enum logic [1:0] {S_IDLE, S_WR, S_RD_WAIT, S_RD_DONE} ppm_state_t;

    ppm_state_t state_reg; // Data phase in progress
    logic [11:0] addr_reg; // Address held from the address phase
    logic take; // Address phase accepted this edge

    // Only NONSEQ/SEQ transfers are taken, reads of any size; non-word writes idle the slave
    assign take = hsel & htrans[1] & hready;

    // Phase sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
        end else if (state_reg == S_RD_WAIT) begin
            state_reg <= S_RD_DONE;
        end else if (take && hwrite && hsize == ppm_pkg::HSIZE_WORD) begin
            state_reg <= S_WR;
        end else if (take && !hwrite) begin
            state_reg <= S_RD_WAIT;
        end else begin
            state_reg <= S_IDLE;
        end
    end

    // Address capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 12'h000;
        end else if (take) begin
            addr_reg <= haddr;
        end
    end

    // Read data sampled in the wait cycle, after any earlier write landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= ppm_pkg::RD_ZERO;
        end else if (state_reg == S_RD_WAIT) begin
            hrdata <= rd_data;
        end
    end

    assign hreadyout = (state_reg != S_RD_WAIT);
    assign hresp = 1'b0;
    assign rd_addr = addr_reg;
    assign wr.en = (state_reg == S_WR);
    assign wr.addr = addr_reg;
    assign wr.data = hwdata;

endmodule

// file: hw/ppm_port_ctrl.sv
// Port pin mode control: mode registers, crossbar gating and pin cells.
// Assumes an outside priority decoder turns the crossbar registers
// and skip bits into per-pin peripheral assignments.
// Data reads give pad levels, not the latch:
// software keeps its own copy of writes.
// Pad controls leave through flip-flops;
// a cycle of latency buys glitch-free pins.
// Pin inputs are taken as synchronous.
// Every register runs on every edge.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.

module ppm_port_ctrl #(
    parameter int NUM_PORTS = ppm_pkg::NUM_PORTS,
    parameter int PIN_W = ppm_pkg::PIN_W
) (

    // System clock and reset
    input wire logic hclk,
    input wire logic hresetn,

    // AHB-Lite slave
    // Single master, word transfers only
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,

    // Pads, one bit per pin, port 0 in the low bits
    // Output enable is active low
    input wire logic [NUM_PORTS*PIN_W-1:0] pad_in,
    output logic [NUM_PORTS*PIN_W-1:0] pad_out,
    output logic [NUM_PORTS*PIN_W-1:0] pad_oe_n,
    output logic [NUM_PORTS*PIN_W-1:0] pad_pullup_en,
    output logic [NUM_PORTS*PIN_W-1:0] pad_rx_en,

    // Peripheral side of the crossbar
    // Inputs driven by the outside decoder
    input wire logic [NUM_PORTS*PIN_W-1:0] periph_assign,
    input wire logic [NUM_PORTS*PIN_W-1:0] periph_out,
    input wire logic [NUM_PORTS*PIN_W-1:0] periph_smbus,
    output logic [NUM_PORTS*PIN_W-1:0] periph_in,

    // Settings handed to the priority decoder
    // Register copies, no logic
    output logic [NUM_PORTS*PIN_W-1:0] crossbar_skip,
    output logic [7:0] crossbar_assign0,
    output logic [7:0] crossbar_assign1,
    output logic crossbar_enable,
    output logic weak_pullup_disable
);

    localparam int NPINS = NUM_PORTS * PIN_W;
    // Pin i is bit i % PIN_W of port i / PIN_W,
    // as in the packed pad vectors

    // Per-port registers, one bit per pin
    logic [PIN_W-1:0] pin_input_mode_reg [NUM_PORTS];
    logic [PIN_W-1:0] pin_output_mode_reg [NUM_PORTS];
    logic [PIN_W-1:0] crossbar_skip_reg [NUM_PORTS];
    logic [PIN_W-1:0] latch_reg [NUM_PORTS];
    // The latch is write-only from the bus;
    // it reaches a pad only through a driver
    // and never comes back to the bus

    // Global crossbar registers
    logic [7:0] crossbar_assign_reg0;
    logic [7:0] crossbar_assign_reg1;
    // Only the enable and pull-up bits act
    // here; the rest is for the decoder

    // Bus front end signals
    ppm_pkg::ppm_wr_t wr; // Write strobe
    logic [11:0] rd_addr; // Address of the read in flight
    logic [31:0] rd_data; // Value for that address
    // rd_data is combinational; the slave
    // registers it in the wait cycle

    // Cell wiring
    ppm_pkg::ppm_cell_cfg_t cell_cfg [NPINS];
    ppm_pkg::ppm_cell_pad_t cell_pad [NPINS];
    logic [NPINS-1:0] cell_rd; // Masked pad readback
    // Struct arrays keep each cell's fields
    // together at no cost in gates

    // Convenience views of the global bits
    logic xbar_en;
    logic wpd;

    assign xbar_en = crossbar_assign_reg1[ppm_pkg::XBAR_EN_BIT];
    assign wpd = crossbar_assign_reg1[ppm_pkg::WPD_BIT];
    // Both reach the pads one edge after the
    // write lands, as the pads are registered

    // Port index of a per-port register address
    // Each port owns a window of four words,
    // PORT_STRIDE bytes apart
    function automatic logic [7:0] port_of(input logic [11:0] a);
        port_of = a[11:4];
    endfunction

    // True when an address falls on a per-port register
    // Misaligned or out-of-range addresses are
    // unmapped: writes vanish, reads give zero
    function automatic logic port_hit(input logic [11:0] a);
        port_hit = (int'(port_of(a)) < NUM_PORTS) && (a[1:0] == 2'b00);
    endfunction

    // Port index cut to an array subscript
    // Used only behind port_hit, so in range
    function automatic int port_idx(input logic [11:0] a);
        port_idx = int'(port_of(a));
    endfunction

    // Bus slave; upper address bits are not decoded
    // The register window repeats across haddr;
    // software must not rely on the aliases
    ppm_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr[11:0]),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        // Register side of the front end
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Input mode registers; reset makes every pin a digital input
    // A cleared bit makes the pin analog:
    // no receiver, no driver, no pull-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                pin_input_mode_reg[p] <= ppm_pkg::RST_IN_MODE;
            end
        end else if (wr.en && port_hit(wr.addr)
                     && wr.addr[3:0] == ppm_pkg::OFS_IN_MODE) begin
            // Upper data bits are dropped
            pin_input_mode_reg[port_idx(wr.addr)] <= wr.data[PIN_W-1:0];
        end
    end

    // Output mode registers; reset gives open-drain
    // Routing never touches these bits, so
    // software sets them even for peripherals
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                pin_output_mode_reg[p] <= ppm_pkg::RST_OUT_MODE;
            end
        end else if (wr.en && port_hit(wr.addr)
                     && wr.addr[3:0] == ppm_pkg::OFS_OUT_MODE) begin
            // One bit per pin, bit n is pin n
            pin_output_mode_reg[port_idx(wr.addr)] <= wr.data[PIN_W-1:0];
        end
    end

    // Crossbar skip registers, consumed only by the outside decoder
    // Analog pins should be skipped so no
    // peripheral lands on a pin with no driver
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                crossbar_skip_reg[p] <= ppm_pkg::RST_SKIP;
            end
        end else if (wr.en && port_hit(wr.addr)
                     && wr.addr[3:0] == ppm_pkg::OFS_SKIP) begin
            // Held for the decoder only
            crossbar_skip_reg[port_idx(wr.addr)] <= wr.data[PIN_W-1:0];
        end
    end

    // Output latches; ones at reset so open-drain pins float
    // A write lands at the end of its data
    // phase; the pad follows one edge later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch_reg[p] <= ppm_pkg::RST_LATCH;
            end
        end else if (wr.en && port_hit(wr.addr)
                     && wr.addr[3:0] == ppm_pkg::OFS_DATA) begin
            // Drives only with the crossbar on
            latch_reg[port_idx(wr.addr)] <= wr.data[PIN_W-1:0];
        end
    end

    // First crossbar assignment register
    // Only the bus read mux reads it; kept for the decoder
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crossbar_assign_reg0 <= ppm_pkg::RST_ASSIGN;
        end else if (wr.en && wr.addr == ppm_pkg::OFS_ASSIGN0) begin
            // Only the low byte exists
            crossbar_assign_reg0 <= wr.data[7:0];
        end
    end

    // Second register holds crossbar enable and pull-up disable
    // Software should set the enable last, or
    // pins may drive before modes are set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crossbar_assign_reg1 <= ppm_pkg::RST_ASSIGN;
        end else if (wr.en && wr.addr == ppm_pkg::OFS_ASSIGN1) begin
            // Both global bits change together
            crossbar_assign_reg1 <= wr.data[7:0];
        end
    end

    // Cell configuration; routing chooses the value, and forces open-drain on SMBus pins
    // SMBus pins go open-drain only while
    // routed; as port pins they keep their mode
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            // Mode bits pass straight to the cell
            cell_cfg[i].digital = pin_input_mode_reg[i / PIN_W][i % PIN_W];
            cell_cfg[i].push_pull = pin_output_mode_reg[i / PIN_W][i % PIN_W];
            cell_cfg[i].force_od = periph_smbus[i] & periph_assign[i];
            // Global bits fan out to every cell
            cell_cfg[i].xbar_en = xbar_en;
            cell_cfg[i].pu_dis = wpd;
            // Peripheral value only once the crossbar applies routing
            if (xbar_en && periph_assign[i]) begin
                cell_cfg[i].out_val = periph_out[i];
            end else begin
                cell_cfg[i].out_val = latch_reg[i / PIN_W][i % PIN_W];
            end
        end
    end

    // One cell per pin
    // Cells are pure logic; state lives here
    for (genvar g = 0; g < NPINS; g++) begin : g_cell
        ppm_pin_cell u_cell (
            .cfg(cell_cfg[g]),
            .pad_in(pad_in[g]),
            .pad(cell_pad[g]),
            .rd_bit(cell_rd[g])
        );
    end

    // Pad controls registered so the pins never glitch on decode
    // Reset leaves pins floating on pull-ups
    // with receivers on, safe for any board
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out <= '0;
            pad_oe_n <= '1;
            pad_pullup_en <= '1;
            pad_rx_en <= '1;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                // Each control copied from its cell
                pad_out[i] <= cell_pad[i].out;
                pad_oe_n[i] <= cell_pad[i].oe_n;
                pad_pullup_en[i] <= cell_pad[i].pullup_en;
                pad_rx_en[i] <= cell_pad[i].rx_en;
            end
        end
    end

    // Received levels to the peripherals; analog pins give zero
    // A cycle of delay keeps the pad path
    // short and free of decode glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_in <= '0;
        end else begin
            // Zero on analog pins, pad level else
            periph_in <= cell_rd;
        end
    end

    // Read mux; the data register returns the pad, not the latch
    // Used in the read's wait cycle, so a write
    // just before the read is already visible;
    // bits above the pin width read zero
    always_comb begin
        rd_data = ppm_pkg::RD_ZERO;
        if (port_hit(rd_addr)) begin
            unique case (rd_addr[3:0])
                // Pad levels, zero on analog pins
                ppm_pkg::OFS_DATA: begin
                    rd_data[PIN_W-1:0] = cell_rd[port_idx(rd_addr)*PIN_W +: PIN_W];
                end
                // Mode bits as written
                ppm_pkg::OFS_IN_MODE: begin
                    rd_data[PIN_W-1:0] = pin_input_mode_reg[port_idx(rd_addr)];
                end
                // Push-pull where a bit is set
                ppm_pkg::OFS_OUT_MODE: begin
                    rd_data[PIN_W-1:0] = pin_output_mode_reg[port_idx(rd_addr)];
                end
                // Skip bits as written
                ppm_pkg::OFS_SKIP: begin
                    rd_data[PIN_W-1:0] = crossbar_skip_reg[port_idx(rd_addr)];
                end
                // Unreachable behind port_hit
                default: begin
                    rd_data = ppm_pkg::RD_ZERO;
                end
            endcase
        end else if (rd_addr == ppm_pkg::OFS_ASSIGN0) begin
            // Global registers sit above the ports
            rd_data[7:0] = crossbar_assign_reg0;
        end else if (rd_addr == ppm_pkg::OFS_ASSIGN1) begin
            rd_data[7:0] = crossbar_assign_reg1;
        end
    end

    // Settings for the outside decoder
    // Flattened: one skip bit per pin
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            // Same pin numbering as the pads
            crossbar_skip[i] = crossbar_skip_reg[i / PIN_W][i % PIN_W];
        end
    end

    // Straight copies; the decoder owns them
    assign crossbar_assign0 = crossbar_assign_reg0;
    assign crossbar_assign1 = crossbar_assign_reg1;
    assign crossbar_enable = xbar_en;
    assign weak_pullup_disable = wpd;

endmodule

// file: tb/ppm_port_ctrl_monitor.sv
// Checker on the top ports of the port pin mode control block.
// Assumes a bind onto ppm_port_ctrl; it sees only that module's ports.
module ppm_port_ctrl_monitor #(
    parameter int NUM_PORTS = ppm_pkg::NUM_PORTS,
    parameter int PIN_W = ppm_pkg::PIN_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_PORTS*PIN_W-1:0] pad_in,
    input wire logic [NUM_PORTS*PIN_W-1:0] pad_oe_n,
    input wire logic [NUM_PORTS*PIN_W-1:0] pad_pullup_en,
    input wire logic [NUM_PORTS*PIN_W-1:0] pad_rx_en,
    input wire logic [NUM_PORTS*PIN_W-1:0] periph_in,
    input wire logic crossbar_enable,
    input wire logic weak_pullup_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain, quiet while reset is low
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Requests taken on the bus
    sequence rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence wr_taken;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    // A read stalls exactly one cycle, then answers
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_reset_state: assert property ($rose(hresetn) |-> &pad_oe_n && &pad_pullup_en)
        else $error("cells not high-Z with pull-up after reset");
    chk_xbar_off_drv: assert property (!$past(crossbar_enable) |-> &pad_oe_n)
        else $error("driver on while crossbar disabled");
    chk_analog_quiet: assert property (((~pad_rx_en & (~pad_oe_n | pad_pullup_en)) == '0))
        else $error("analog pin still driven or pulled up");
    chk_pud_all_off: assert property ($past(weak_pullup_disable) |-> pad_pullup_en == '0)
        else $error("pull-up on while globally disabled");
    chk_pu_drive_off: assert property ((pad_pullup_en & ~pad_oe_n) == '0)
        else $error("pull-up on while cell drives");
    chk_pad_readback: assert property ($past(hresetn) |-> periph_in == ($past(pad_in) & pad_rx_en))
        else $error("input path not pad level masked by mode");
    chk_read_wait: assert property (rd_taken |=> rd_answer)
        else $error("read answer timing wrong");
    chk_write_nowait: assert property (wr_taken |=> hreadyout && !hresp)
        else $error("write stalled or refused");
    // Crossbar on with pull-ups not disabled, at least once
    cov_xbar_on: cover property (crossbar_enable && !weak_pullup_disable);
endmodule

// file: tb/ppm_pad_model.sv
// Pad model: resolves each pad from the cell, an outside driver and the pull-up.
// Assumes one bit per pin; the system clock paces the floating pattern.
module ppm_pad_model #(
    parameter int N = 56
) (
    input wire logic hclk,
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe_n,
    input wire logic [N-1:0] pad_pullup_en,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] float_reg = '0; // Level of a pad nobody holds
    // A floating pad flips every cycle so a lucky guess cannot pass
    always_ff @(posedge hclk) begin
        float_reg <= ~float_reg;
    end
    // Cell first, then the outside driver, then the weak pull-up
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
            else pad_in[i] = float_reg[i];
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the port pin mode control block.
// Assumes the package, the pad model and the monitor are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NP = 2; // Two ports keep the model loops short
    localparam int N = NP * 8;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic hready, hreadyout, hresp, xen, wpd;
    logic [N-1:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, pad_rx_en, periph_in, skip_o;
    logic [N-1:0] pa = '0, po = '0, ps = '0, ext_en = '0, ext = '0;
    logic [7:0] as0_o, as1_o, a0, a1;
    logic [7:0] in_m [NP], out_m [NP], lat [NP];
    int err_total = 0, comparisons = 0, cyc = 0;
    assign hready = hreadyout; // Single slave drives the bus ready
    always #20 hclk = ~hclk;
    ppm_port_ctrl #(.NUM_PORTS(NP), .PIN_W(8)) i_dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout, .hresp, .hrdata, .pad_in,
        .pad_out, .pad_oe_n, .pad_pullup_en, .pad_rx_en, .periph_assign(pa),
        .periph_out(po), .periph_smbus(ps), .periph_in, .crossbar_skip(skip_o),
        .crossbar_assign0(as0_o), .crossbar_assign1(as1_o), .crossbar_enable(xen),
        .weak_pullup_disable(wpd));
    ppm_pad_model #(.N(N)) i_pads (.hclk, .pad_out, .pad_oe_n, .pad_pullup_en,
        .ext_en, .ext_val(ext), .pad_in);
    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single transfer; ready is read at the falling edge, race free
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [2:0] sz, output logic [31:0] r);
        logic rdy;
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= sz;
        do begin
            @(negedge hclk); rdy = hreadyout; @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do begin
            @(negedge hclk); rdy = hreadyout; r = hrdata; @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask
    task automatic wr(input int a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, 32'(a), d, ppm_pkg::HSIZE_WORD, r);
    endtask
    task automatic rd_chk(input int a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, 32'(a), 32'h0000_0000, ppm_pkg::HSIZE_WORD, r);
        chk(r, exp);
    endtask
    // Model of every pad control and readback, from the mode registers
    task automatic check_all();
        logic [N-1:0] eo, eu, ep, ed;
        logic d, ov, pp, drv;
        for (int i = 0; i < N; i++) begin
            d = in_m[i/8][i%8];
            ov = pa[i] ? po[i] : lat[i/8][i%8];
            pp = out_m[i/8][i%8] & ~(pa[i] & ps[i]);
            drv = d & a1[6] & (pp | ~ov);
            eo[i] = ~drv;
            eu[i] = pp & ov;
            ep[i] = d & ~a1[7] & ~drv;
            ed[i] = (drv ? eu[i] : ext[i]) & d;
        end
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk(pad_oe_n, eo);
        chk(pad_out & ~eo, eu & ~eo);
        chk(pad_pullup_en, ep);
        chk(pad_rx_en, {in_m[1], in_m[0]});
        chk(periph_in, ed);
        chk({xen, wpd, as1_o, as0_o, skip_o}, {a1[6], a1[7], a1, a0, ~in_m[1], ~in_m[0]});
        rd_chk(256, {24'h00_0000, a0});
        rd_chk(260, {24'h00_0000, a1});
        for (int p = 0; p < NP; p++) begin
            rd_chk(p * 16, {24'h00_0000, ed[p*8+:8]});
            rd_chk(p * 16 + 4, {24'h00_0000, in_m[p]});
            rd_chk(p * 16 + 8, {24'h00_0000, out_m[p]});
            rd_chk(p * 16 + 12, {24'h00_0000, ~in_m[p]});
        end
    endtask
    initial begin
        logic [31:0] r;
        void'($urandom(32'h0000_87b8));
        // Reset, then reset values and refused accesses
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk({pad_oe_n, pad_pullup_en, pad_rx_en}, {(3 * N){1'b1}});
        rd_chk(0, 32'h0000_00FF);
        rd_chk(4, 32'h0000_00FF);
        rd_chk(8, 32'h0000_0000);
        rd_chk(260, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0000, 3'h0, r);
        rd_chk(4, 32'h0000_00FF);
        wr(240, 32'h0000_00FF);
        rd_chk(240, 32'h0000_0000);
        $display("test reset done");
        // Random configurations written in the set-up order
        ext_en <= {N{1'b1}};
        for (int it = 0; it < 30; it++) begin
            a0 = 8'($urandom);
            a1 = 8'($urandom);
            @(posedge hclk);
            pa <= N'($urandom);
            po <= N'($urandom);
            ps <= N'($urandom);
            ext <= N'($urandom);
            for (int p = 0; p < NP; p++) begin
                in_m[p] = 8'($urandom);
                out_m[p] = 8'($urandom);
                lat[p] = 8'($urandom);
                wr(p * 16 + 4, {24'h00_0000, in_m[p]});
            end
            for (int p = 0; p < NP; p++) wr(p * 16 + 8, {24'h00_0000, out_m[p]});
            for (int p = 0; p < NP; p++) wr(p * 16 + 12, {24'h00_0000, ~in_m[p]});
            for (int p = 0; p < NP; p++) wr(p * 16, {24'h00_0000, lat[p]});
            wr(256, {24'h00_0000, a0});
            wr(260, {24'h00_0000, a1});
            check_all();
        end
        $display("test random modes done");
        wrap_up();
    end
endmodule
bind ppm_port_ctrl ppm_port_ctrl_monitor #(.NUM_PORTS(NUM_PORTS), .PIN_W(PIN_W)) i_mon (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .pad_in,
    .pad_oe_n, .pad_pullup_en, .pad_rx_en, .periph_in, .crossbar_enable,
    .weak_pullup_disable);
